/* File: design/irq_requester_defines.svh */
// Timing counts, level encodings and the default vector for the interrupt requester.
// Assumes a 50 MHz system clock; included by the package and the requester module.
`ifndef IRQ_REQUESTER_DEFINES_SVH
`define IRQ_REQUESTER_DEFINES_SVH
`define CLK_PERIOD_NS 20
// Longest chain pass-through delay per slot, in ns, and cycles (rounded down).
`define CHAIN_PASS_MAX_NS 500
`define CHAIN_PASS_CYC (`CHAIN_PASS_MAX_NS / `CLK_PERIOD_NS)
// Longest time from chain acknowledge to reply, in ns, and cycles (rounded down).
`define REPLY_MAX_NS 10000
`define REPLY_MAX_CYC (`REPLY_MAX_NS / `CLK_PERIOD_NS)
// Vector settle time after reply, and removal time after reply drops.
`define VEC_SETTLE_MAX_NS 125
`define VEC_SETTLE_CYC (`VEC_SETTLE_MAX_NS / `CLK_PERIOD_NS)
`define VEC_REMOVE_MAX_NS 100
`define VEC_REMOVE_CYC (`VEC_REMOVE_MAX_NS / `CLK_PERIOD_NS)
// Vectors must lie below this byte address (octal 001000).
`define VECTOR_LIMIT 16'h0200
`define VECTOR_DEFAULT 16'h0040
// Priority level encodings.
`define LVL_4 2'h0
`define LVL_5 2'h1
`define LVL_6 2'h2
`define LVL_7 2'h3
`endif

/* File: design/irq_requester_pkg.sv */
// Types shared by the interrupt requester modules.
// Assumes the defines header is on the include path.
`include "irq_requester_defines.svh"
package irq_requester_pkg;
    // Request lines, active high inside the device: a=4, b=5, c=6, d=7.
    typedef struct packed {
        logic lvl_d;
        logic lvl_c;
        logic lvl_b;
        logic lvl_a;
    } irq_lines_t;
    typedef enum logic [1:0] {
        SCHEME_FOUR_INDEP,
        SCHEME_FOUR_DEP,
        SCHEME_SINGLE
    } scheme_t;
endpackage

/* File: design/bus_sync.sv */
// Two-stage synchroniser for a vector of asynchronous bus inputs.
// Assumes the inputs are levels that stay stable for several clock cycles.
`timescale 1ns/1ns
module bus_sync #(
    parameter int WIDTH = 7
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

/* File: design/bus_vectored_interrupt_requester.sv */
// Device-side interrupt requester for an asynchronous multiplexed backplane bus.
// Assumes bus pins are inverted and open-collector outside; here all are active high.
`timescale 1ns/1ns
`include "irq_requester_defines.svh"
module bus_vectored_interrupt_requester #(
    parameter logic [1:0] LEVEL = `LVL_4,
    parameter irq_requester_pkg::scheme_t SCHEME = irq_requester_pkg::SCHEME_FOUR_INDEP,
    parameter logic [15:0] VECTOR = `VECTOR_DEFAULT
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic int_enable_in,
    input wire logic cond_ready_in,
    input wire logic cond_done_in,
    input wire logic cond_error_in,
    input wire logic input_strobe_in,
    input wire logic ack_chain_in,
    input wire irq_requester_pkg::irq_lines_t irq_lines_in,
    output irq_requester_pkg::irq_lines_t irq_lines_out,
    output logic ack_chain_out,
    output logic reply_strobe_out,
    output logic [15:0] muxed_addr_data_lines_out,
    output logic [15:0] muxed_addr_data_lines_oe_out,
    output logic pending_out
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_REQ,
        ST_PASS,
        ST_VECTOR
    } state_t;

    state_t state_q;
    state_t state_d;
    logic strobe_prev_q;
    logic block_q;
    logic [5:0] sync_w;
    logic strobe_s;
    logic ack_s;
    irq_requester_pkg::irq_lines_t lines_s;

    // Strobe, chain input and the four request lines all come from the bus.
    bus_sync #(
        .WIDTH(6)
    ) u_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .async_in({input_strobe_in, ack_chain_in, irq_lines_in}),
        .sync_out(sync_w)
    );
    assign strobe_s = sync_w[5];
    assign ack_s = sync_w[4];
    assign lines_s = irq_requester_pkg::irq_lines_t'(sync_w[3:0]);

    // Lines asserted for a request at a given level, with the scheme applied.
    function automatic irq_requester_pkg::irq_lines_t lines_for(input logic [1:0] lvl);
        irq_requester_pkg::irq_lines_t l;
        l = '0;
        l.lvl_a = 1'b1;
        l.lvl_b = (lvl == `LVL_5);
        l.lvl_c = (lvl == `LVL_6) ||
            ((lvl == `LVL_7) && (SCHEME != irq_requester_pkg::SCHEME_FOUR_DEP));
        l.lvl_d = (lvl == `LVL_7);
        return l;
    endfunction

    // Whether a higher-priority request is visible to this level.
    function automatic logic higher_active(input logic [1:0] lvl,
        input irq_requester_pkg::irq_lines_t l);
        logic h;
        h = 1'b0;
        case (lvl)
            `LVL_4: h = l.lvl_b | l.lvl_c;
            `LVL_5: h = l.lvl_c;
            `LVL_6: h = l.lvl_d;
            default: h = 1'b0;
        endcase
        return h;
    endfunction

    logic req_cond_w;
    logic strobe_rise_w;
    logic must_check_w;
    logic lose_w;
    assign req_cond_w = int_enable_in & (cond_ready_in | cond_done_in | cond_error_in);
    assign strobe_rise_w = strobe_s & ~strobe_prev_q;
    assign must_check_w = (SCHEME == irq_requester_pkg::SCHEME_FOUR_INDEP);
    assign lose_w = must_check_w & higher_active(LEVEL, lines_s);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                if (req_cond_w)
                begin
                    state_d = ST_REQ;
                end
                else if (ack_s)
                begin
                    state_d = ST_PASS;
                end
            end
            ST_REQ:
            begin
                if (ack_s && block_q)
                begin
                    state_d = ST_VECTOR;
                end
                else if (ack_s && !block_q)
                begin
                    state_d = ST_PASS;
                end
            end
            ST_PASS:
            begin
                if (!ack_s)
                begin
                    // A withdrawn requester still owes its request, so it rearms.
                    state_d = (req_cond_w || irq_lines_out.lvl_a) ? ST_REQ : ST_IDLE;
                end
            end
            ST_VECTOR:
            begin
                if (!strobe_s && !ack_s)
                begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // Blocking flip-flop, taken on the strobe leading edge while requesting.
    logic block_d;
    assign block_d = (state_q == ST_REQ && strobe_rise_w) ? ~lose_w :
        (state_d == ST_VECTOR || state_d == ST_REQ) ? block_q : 1'b0;

    // A withdrawn requester keeps its lines up until the processor acknowledges it later.
    logic requesting_d;
    assign requesting_d = (state_d == ST_REQ) || (state_d == ST_PASS && state_q == ST_REQ)
        || (state_d == ST_PASS && state_q == ST_PASS && irq_lines_out.lvl_a);
    logic vec_d;
    assign vec_d = (state_d == ST_VECTOR) && strobe_s && ack_s;
    irq_requester_pkg::irq_lines_t lines_d;
    logic chain_d;
    logic [15:0] vec_data_d;
    logic [15:0] vec_oe_d;
    logic pending_d;
    assign lines_d = requesting_d ? lines_for(LEVEL) : '0;
    assign chain_d = (state_d == ST_PASS) && ack_s;
    assign vec_data_d = vec_d ? VECTOR : 16'h0000;
    assign vec_oe_d = vec_d ? 16'hffff : 16'h0000;
    assign pending_d = requesting_d || (state_d == ST_VECTOR);

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_q <= ST_IDLE;
            strobe_prev_q <= 1'b0;
            block_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            strobe_prev_q <= strobe_s;
            block_q <= block_d;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            irq_lines_out <= '0;
            ack_chain_out <= 1'b0;
            reply_strobe_out <= 1'b0;
            muxed_addr_data_lines_out <= 16'h0000;
            muxed_addr_data_lines_oe_out <= 16'h0000;
            pending_out <= 1'b0;
        end
        else
        begin
            irq_lines_out <= lines_d;
            ack_chain_out <= chain_d;
            reply_strobe_out <= vec_d;
            // Vector and reply move together, well inside the settle and removal limits.
            muxed_addr_data_lines_out <= vec_data_d;
            muxed_addr_data_lines_oe_out <= vec_oe_d;
            pending_out <= pending_d;
        end
    end

    // Helper counter for chain acknowledge to reply latency.
    logic [9:0] ack_wait_q;
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ack_wait_q <= 10'h000;
        end
        else
        begin
            ack_wait_q <= (ack_s && !reply_strobe_out && !ack_chain_out && state_q != ST_IDLE) ?
                ack_wait_q + 10'h001 : 10'h000;
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_no_req_unenabled: assert property (
        $rose(irq_lines_out.lvl_a) |-> $past(int_enable_in, 2) || $past(int_enable_in))
        else $error("Request started without enable.");
    a_lvl4_always: assert property (
        (irq_lines_out != '0) |-> irq_lines_out.lvl_a)
        else $error("Level-4 line missing from request.");
    a_lvl7_drives6: assert property (
        irq_lines_out.lvl_d && SCHEME != irq_requester_pkg::SCHEME_FOUR_DEP |-> irq_lines_out.lvl_c)
        else $error("Level-7 request without level-6 line.");
    a_req_held: assert property (
        (state_q == ST_REQ && state_d == ST_REQ) |=> irq_lines_out.lvl_a)
        else $error("Request dropped before acknowledge.");
    a_pass_idle: assert property (
        (state_q == ST_IDLE && !req_cond_w && ack_s) |=> ack_chain_out)
        else $error("Idle device did not pass acknowledge.");
    a_block_win: assert property (
        (state_q == ST_REQ && strobe_rise_w && !lose_w) |=> block_q)
        else $error("Block flip-flop not set on strobe edge.");
    a_higher_pass: assert property (
        (state_q == ST_REQ && strobe_rise_w && lose_w) |=> !block_q)
        else $error("Device blocked despite higher request.");
    a_reply_vector: assert property (
        reply_strobe_out |-> (muxed_addr_data_lines_out == VECTOR)
            && (muxed_addr_data_lines_oe_out == 16'hffff))
        else $error("Reply without vector on lines.");
    a_vector_remove: assert property (
        $fell(reply_strobe_out) |-> muxed_addr_data_lines_oe_out == 16'h0000)
        else $error("Vector not removed with reply.");
    a_reply_latency: assert property (
        ack_wait_q < 10'(`REPLY_MAX_CYC))
        else $error("Reply too late after acknowledge.");
    a_vector_range: assert property (
        muxed_addr_data_lines_oe_out != 16'h0000 |-> muxed_addr_data_lines_out < `VECTOR_LIMIT)
        else $error("Vector outside designated range.");
    a_unblock_end: assert property (
        (state_q == ST_VECTOR && !strobe_s && !ack_s) |=> !block_q)
        else $error("Block flip-flop not cleared after handshake.");

    // Two of the per-slot pass cycles are already spent in the input synchroniser.
    localparam int PASS_SLACK = `CHAIN_PASS_CYC - 2;

    a_pass_latency: assert property (
        ($rose(ack_s) && ((state_q == ST_IDLE && !req_cond_w)
            || (state_q == ST_REQ && !block_q)))
            |-> ##[1:PASS_SLACK] ack_chain_out)
        else $error("Chain acknowledge not passed in time.");
    a_single_blocks: assert property (
        (SCHEME == irq_requester_pkg::SCHEME_SINGLE && state_q == ST_REQ && strobe_rise_w)
            |=> block_q)
        else $error("Single-level requester did not block.");
    a_dep_lines: assert property (
        (SCHEME == irq_requester_pkg::SCHEME_FOUR_DEP && irq_lines_out.lvl_a)
            |-> irq_lines_out.lvl_c == (LEVEL == `LVL_6))
        else $error("Position-dependent device drove a foreign level.");
    a_dep_no_monitor: assert property (
        (SCHEME != irq_requester_pkg::SCHEME_FOUR_INDEP) |-> !lose_w)
        else $error("Monitoring active in a scheme without it.");
    a_top_no_monitor: assert property (
        (LEVEL == `LVL_7) |-> !lose_w)
        else $error("Level-7 device withdrew.");
    a_vector_stable: assert property (
        (reply_strobe_out && $past(reply_strobe_out)) |-> $stable(muxed_addr_data_lines_out))
        else $error("Vector moved while reply stands.");
    a_vector_drop: assert property (
        (state_q == ST_VECTOR && !strobe_s && !ack_s)
            |=> !reply_strobe_out && muxed_addr_data_lines_oe_out == 16'h0000)
        else $error("Reply or vector held after handshake.");
    a_reply_needs_both: assert property (
        $rose(reply_strobe_out) |-> $past(strobe_s) && $past(ack_s))
        else $error("Reply without strobe and acknowledge.");
    a_vector_needs_win: assert property (
        $rose(reply_strobe_out) |-> $past(block_q))
        else $error("Reply without a won arbitration.");
    a_blocked_no_pass: assert property (
        block_q |-> !ack_chain_out)
        else $error("Blocked acknowledge passed onward.");
    a_idle_quiet: assert property (
        (state_q == ST_IDLE && state_d == ST_IDLE) |=> irq_lines_out == '0)
        else $error("Request lines up while idle.");
    a_idle_no_chain: assert property (
        (state_q == ST_IDLE && !ack_s) |=> !ack_chain_out)
        else $error("Chain output without acknowledge input.");
    a_chain_follows: assert property (
        ack_chain_out |-> $past(ack_s))
        else $error("Chain output without prior acknowledge.");
    a_pass_no_reply: assert property (
        ack_chain_out |-> !reply_strobe_out)
        else $error("Reply while passing the acknowledge.");
    a_withdraw_keeps: assert property (
        (state_q == ST_PASS && irq_lines_out.lvl_a) |=> irq_lines_out.lvl_a)
        else $error("Withdrawn request dropped early.");
    a_lvl5_only: assert property (
        irq_lines_out.lvl_b |-> (LEVEL == `LVL_5))
        else $error("Level-5 line from another level.");
    a_lvl7_own: assert property (
        irq_lines_out.lvl_d |-> (LEVEL == `LVL_7))
        else $error("Level-7 line from another level.");
    a_lvl6_source: assert property (
        irq_lines_out.lvl_c |-> (LEVEL == `LVL_6)
            || (LEVEL == `LVL_7 && SCHEME != irq_requester_pkg::SCHEME_FOUR_DEP))
        else $error("Level-6 line driven without cause.");
    a_oe_all: assert property (
        muxed_addr_data_lines_oe_out != 16'h0000 |-> muxed_addr_data_lines_oe_out == 16'hffff)
        else $error("Vector driven on part of the lines.");
    a_data_quiet: assert property (
        !reply_strobe_out |-> muxed_addr_data_lines_out == 16'h0000)
        else $error("Vector left on lines without reply.");
    a_pending_req: assert property (
        irq_lines_out.lvl_a |-> pending_out)
        else $error("Request up without pending flag.");

    c_request: cover property ($rose(irq_lines_out.lvl_a));
    c_win: cover property ($rose(reply_strobe_out));
    c_pass: cover property ($rose(ack_chain_out));
    c_withdraw: cover property (state_q == ST_REQ && state_d == ST_PASS);
    c_rearm: cover property (state_q == ST_PASS && state_d == ST_REQ);
endmodule

/* File: tb/irq_host_model.sv */
// Behavioural host processor that grants one interrupt at a time.
// Assumes it sits next to the device, so its acknowledge goes straight in.
`timescale 1ns/1ns
module irq_host_model (
    input wire logic clk_in,
    input wire logic reply_in,
    input wire logic chain_out_in,
    input wire logic [15:0] data_in,
    input wire logic [15:0] oe_in,
    output logic strobe_out,
    output logic ack_out
);
    initial
    begin
        strobe_out = 1'b0;
        ack_out = 1'b0;
    end

    // Counts are cycles after the acknowledge rises; -1 means it never came.
    task automatic grant(output logic [15:0] vec, output logic [15:0] oe, output int rep_cyc,
                         output int pass_cyc);
        int n;
        vec = 16'h0000;
        oe = 16'h0000;
        rep_cyc = -1;
        pass_cyc = -1;
        // Each grant starts between bus cycles and only one is ever outstanding.
        @(posedge clk_in);
        strobe_out <= 1'b1;
        repeat (8) @(posedge clk_in);
        ack_out <= 1'b1;
        for (n = 1; n <= 600 && rep_cyc < 0; n++)
        begin
            @(posedge clk_in);
            if (chain_out_in === 1'b1 && pass_cyc < 0)
                pass_cyc = n;
            if (reply_in === 1'b1)
                rep_cyc = n;
        end
        // Reading late proves the vector is settled, not merely present at reply.
        if (rep_cyc >= 0)
        begin
            repeat (7) @(posedge clk_in);
            vec = data_in;
            oe = oe_in;
        end
        strobe_out <= 1'b0;
        ack_out <= 1'b0;
        for (n = 0; n < 50 && reply_in !== 1'b0; n++)
            @(posedge clk_in);
    endtask
endmodule

/* File: tb/bus_vectored_interrupt_requester_tb.sv */
// Self-checking bench for a level-4 position-independent and a level-7 single-level requester.
// Assumes the host model is first on the chain; other devices are a mask.
`timescale 1ns/1ns
module bus_vectored_interrupt_requester_tb;
    localparam logic [15:0] VEC = 16'h0064;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic int_enable = 1'b0;
    logic cond_ready = 1'b0;
    logic cond_done = 1'b0;
    logic cond_error = 1'b0;
    logic [3:0] other_q = 4'h0;
    logic strobe, ack, chain_out, reply, pending;
    logic [15:0] data, oe, vec, seen_oe;
    irq_requester_pkg::irq_lines_t lines_out, bus_lines;
    int rep, pass, fails = 0, n_compared = 0, cycles = 0;
    localparam logic [15:0] VEC7 = 16'h00a8;
    logic en7 = 1'b0;
    logic chain7, reply7, pending7;
    logic seen7 = 1'b0;
    logic pass7_q = 1'b0;
    logic [15:0] data7;
    logic [15:0] vec7_q = 16'h0000;
    irq_requester_pkg::irq_lines_t lines7;

    // The request lines are wired-OR, so the device sees its own drive too.
    assign bus_lines = irq_requester_pkg::irq_lines_t'(other_q | lines_out);

    bus_vectored_interrupt_requester #(.LEVEL(2'h0),
        .SCHEME(irq_requester_pkg::SCHEME_FOUR_INDEP), .VECTOR(VEC)) DUT (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .int_enable_in(int_enable),
        .cond_ready_in(cond_ready), .cond_done_in(cond_done), .cond_error_in(cond_error),
        .input_strobe_in(strobe), .ack_chain_in(ack), .irq_lines_in(bus_lines),
        .irq_lines_out(lines_out), .ack_chain_out(chain_out), .reply_strobe_out(reply),
        .muxed_addr_data_lines_out(data), .muxed_addr_data_lines_oe_out(oe),
        .pending_out(pending));

    // The level-7 device keeps its lines off the shared bus so the level-4 tests stay clean.
    bus_vectored_interrupt_requester #(.LEVEL(2'h3),
        .SCHEME(irq_requester_pkg::SCHEME_SINGLE), .VECTOR(VEC7)) DUT_L7 (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .int_enable_in(en7),
        .cond_ready_in(cond_ready), .cond_done_in(cond_done), .cond_error_in(cond_error),
        .input_strobe_in(strobe), .ack_chain_in(ack), .irq_lines_in(bus_lines),
        .irq_lines_out(lines7), .ack_chain_out(chain7), .reply_strobe_out(reply7),
        .muxed_addr_data_lines_out(data7), .muxed_addr_data_lines_oe_out(),
        .pending_out(pending7));

    // The level-7 reply stands only while the host holds its grant, so it is latched here.
    always @(posedge clk_in)
    begin
        if (reply7 === 1'b1)
        begin
            seen7 <= 1'b1;
            vec7_q <= data7;
        end
        if (chain7 === 1'b1)
            pass7_q <= 1'b1;
    end

    irq_host_model host (.clk_in(clk_in), .reply_in(reply), .chain_out_in(chain_out),
        .data_in(data), .oe_in(oe), .strobe_out(strobe), .ack_out(ack));

    initial
    begin
        forever #10 clk_in = ~clk_in;
    end

    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 12000)
        begin
            fails++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (fails == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic raise(input int which);
        @(posedge clk_in);
        int_enable <= 1'b1;
        if (which == 0)
            cond_ready <= 1'b1;
        else
            cond_done <= 1'b1;
        @(posedge clk_in);
        cond_ready <= 1'b0;
        cond_done <= 1'b0;
        repeat (3) @(posedge clk_in);
        check("lines_req", 32'h1, lines_out);
    endtask

    task automatic expect_pass(input logic [3:0] lines_exp);
        host.grant(vec, seen_oe, rep, pass);
        check("pass_ok", 32'h1, pass > 0 && pass <= 25);
        check("no_reply", 32'hffffffff, rep);
        check("lines_after_pass", lines_exp, lines_out);
        repeat (5) @(posedge clk_in);
    endtask

    task automatic expect_win();
        host.grant(vec, seen_oe, rep, pass);
        check("reply_time", 32'h1, rep > 0 && rep <= 500);
        check("blocked", 32'hffffffff, pass);
        check("vector", VEC, vec);
        check("vector_range", 32'h1, vec < 16'h0200);
        check("vector_oe", 16'hffff, seen_oe);
        repeat (5) @(posedge clk_in);
        check("reply_off", 32'h0, reply);
        check("oe_off", 32'h0, oe);
        check("lines_off", 32'h0, lines_out);
        check("pending_off", 32'h0, pending);
    endtask

    task automatic t_disabled();
        @(posedge clk_in);
        cond_error <= 1'b1;
        repeat (5) @(posedge clk_in);
        check("lines_dis", 32'h0, lines_out);
        expect_pass(4'h0);
        cond_error <= 1'b0;
    endtask

    task automatic t_level7();
        @(posedge clk_in);
        en7 <= 1'b1;
        cond_error <= 1'b1;
        @(posedge clk_in);
        cond_error <= 1'b0;
        repeat (3) @(posedge clk_in);
        check("lines7_req", 32'hd, lines7);
        check("lines_unenabled", 32'h0, lines_out);
        expect_pass(4'h0);
        check("reply7_seen", 32'h1, seen7);
        check("pass7_blocked", 32'h0, pass7_q);
        check("vector7", VEC7, vec7_q);
        check("reply7_off", 32'h0, reply7);
        check("lines7_off", 32'h0, lines7);
        check("pending7_off", 32'h0, pending7);
        en7 <= 1'b0;
    endtask

    task automatic t_withdraw_then_win();
        logic [3:0] hi [2] = '{4'h2, 4'h4};
        raise(0);
        repeat (20) @(posedge clk_in);
        check("lines_hold", 32'h1, lines_out);
        check("pending_on", 32'h1, pending);
        foreach (hi[i])
        begin
            other_q <= hi[i];
            repeat (3) @(posedge clk_in);
            expect_pass(4'h1);
        end
        // Level 7 alone is not watched by a level-4 device, so it still wins.
        other_q <= 4'h8;
        repeat (3) @(posedge clk_in);
        expect_win();
        other_q <= 4'h0;
    endtask

    task automatic t_rearm();
        raise(1);
        expect_win();
        expect_pass(4'h0);
    endtask

    initial
    begin
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        check("lines_rst", 32'h0, lines_out);
        check("chain_rst", 32'h0, chain_out);
        check("reply_rst", 32'h0, reply);
        t_level7();
        t_disabled();
        t_withdraw_then_win();
        t_rearm();
        stop_test();
    end
endmodule
